// ==== core/pid_regulator_feedforward.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: error is target minus measured value.
// RQ2: output sums proportional, integral, derivative terms, each with its own gain.
// RQ3: accumulated integral is clamped to the integration limit magnitude.
// RQ4: derivative is low-pass filtered by the delay setting; zero means no filter.
// RQ5: speed feedforward adds friction gain times rotational speed.
// RQ6: acceleration feedforward adds inertia gain times target acceleration.
// RQ7: during ramp moves feedforward uses ramp target speed and acceleration.
// RQ8: errors smaller than the dead band are treated as zero.
// RQ9: dead band of zero disables the feature.
// RQ10: following error readable as signed 16 bits, updated every sample.
// RQ11: reported error is 16 counts per position step, saturated.
// RQ12: over-error flag set when error magnitude exceeds maximum, sticky.
// RQ13: torque request readable as signed 16 bits.
// RQ14: with all feedback gains zero only feedforward remains.
// RQ15: one computation per fixed sample period, output saturated to 16 bits.
module pid_regulator_feedforward #(
    parameter int SAMPLE_CYCLES = regulator_pkg::SAMPLE_CYCLES
) (
    input wire logic hclk, // bus and regulator clock
    input wire logic hresetn, // asynchronous reset
    input wire logic ce, // clock enable, freezes all state
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write access
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // response
    input wire regulator_pkg::feedback_t fb, // measurement and target inputs
    output logic signed [15:0] torque_request, // regulator output
    output logic over_error, // sticky over-error flag
    output logic irq // level interrupt
);

    // ---------------- bus slave ----------------
    logic wr_pend_q;
    logic [9:0] wr_idx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    wire addr_phase = hsel & hready & (htrans == regulator_pkg::HTRANS_NONSEQ);
    wire in_range = (haddr[31:regulator_pkg::ADDR_MSB+1] == '0);
    wire [9:0] a_idx = haddr[regulator_pkg::ADDR_MSB:regulator_pkg::ADDR_LSB];
    wire rd_start = addr_phase & ~hwrite;
    wire wr_start = addr_phase & hwrite & in_range;

    // ---------------- software registers ----------------
    logic signed [15:0] prop_gain_q;
    logic signed [15:0] int_gain_q;
    logic signed [15:0] deriv_gain_q;
    logic signed [15:0] integral_limit_q;
    logic [15:0] deriv_delay_q;
    logic signed [15:0] speed_ff_gain_q;
    logic signed [15:0] accel_ff_gain_q;
    logic [15:0] dead_band_q;
    logic [15:0] err_max_q;
    logic enable_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;

    wire wr_kp = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_PROP_GAIN);
    wire wr_ki = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_INT_GAIN);
    wire wr_kd = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_DERIV_GAIN);
    wire wr_lim = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_INTEGRAL_LIMIT);
    wire wr_dly = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_DERIV_DELAY);
    wire wr_sff = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_SPEED_FF_GAIN);
    wire wr_aff = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_ACCEL_FF_GAIN);
    wire wr_db = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_DEAD_BAND);
    wire wr_emax = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_FOLLOW_ERR_MAX);
    wire wr_ctrl = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_CONTROL);
    wire wr_stat = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_IRQ_STATUS);
    wire wr_mask = wr_pend_q & (wr_idx_q == regulator_pkg::IDX_IRQ_MASK);

    // ---------------- regulator state ----------------
    regulator_pkg::reg_state_t state_q;
    regulator_pkg::reg_state_t state_d;
    logic [31:0] sample_cnt_q;
    logic signed [15:0] follow_err_q;
    logic signed [15:0] err_q;
    logic signed [15:0] err_prev_q;
    logic signed [15:0] integ_q;
    logic signed [16:0] dfilt_q;
    logic signed [15:0] torque_q;
    logic [1:0] evt_set;

    function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
        if (v > 48'sd32767)
        begin
            sat16 = 16'sh7fff;
        end
        else if (v < -48'sd32768)
        begin
            sat16 = -16'sh8000;
        end
        else
        begin
            sat16 = v[15:0];
        end
    endfunction

    function automatic logic [16:0] mag17(input logic signed [15:0] v);
        mag17 = v[15] ? (17'h0_0000 - {v[15], v}) : {1'b0, v};
    endfunction

    // sample period tick
    wire sample_tick = enable_q && (sample_cnt_q == 32'(SAMPLE_CYCLES - 1)); // RQ15

    // error in position steps, then scaled to report units
    wire signed [32:0] diff = {fb.target[31], fb.target} - {fb.position[31], fb.position}; // RQ1
    wire signed [47:0] diff_scaled = 48'(diff) <<< regulator_pkg::ERR_SCALE_SHIFT; // RQ11
    wire signed [15:0] err_report = sat16(diff_scaled); // RQ11
    wire [16:0] err_mag = mag17(err_report);
    wire db_off = (dead_band_q == 16'h0000); // RQ9
    wire in_dead_band = !db_off && (err_mag < {1'b0, dead_band_q}); // RQ8
    wire signed [15:0] err_banded = in_dead_band ? 16'sh0000 : err_report; // RQ8
    wire err_exceeds = err_mag > {1'b0, err_max_q}; // RQ12

    // integral with clamp; a negative limit is treated as no integral at all
    wire signed [16:0] lim_pos = integral_limit_q[15] ? 17'sh0_0000 : {1'b0, integral_limit_q};
    wire signed [16:0] integ_sum = {integ_q[15], integ_q} + {err_q[15], err_q};
    wire signed [16:0] integ_clamped = (integ_sum > lim_pos) ? lim_pos :
                                       (integ_sum < -lim_pos) ? -lim_pos : integ_sum; // RQ3

    // derivative first-order filter, shift limited to the documented range
    wire [3:0] dly_shift = (deriv_delay_q > 16'(regulator_pkg::DELAY_MAX)) ?
                           regulator_pkg::DELAY_MAX : deriv_delay_q[3:0]; // RQ4
    wire signed [16:0] d_raw = {err_q[15], err_q} - {err_prev_q[15], err_prev_q};
    // signed wire so the shift below fills with the sign for every delay setting
    wire signed [17:0] d_gap = {d_raw[16], d_raw} - {dfilt_q[16], dfilt_q};
    wire signed [17:0] d_step = d_gap >>> dly_shift; // RQ4
    wire signed [17:0] dfilt_sum = {dfilt_q[16], dfilt_q} + d_step;
    wire signed [16:0] dfilt_next = dfilt_sum[16:0]; // RQ4

    // feedforward sources: ramp values during ramp moves, measured speed and zero acceleration otherwise
    wire signed [15:0] ff_speed = fb.ramp_active ? fb.ramp_speed : fb.speed; // RQ7
    wire signed [15:0] ff_accel = fb.ramp_active ? fb.ramp_accel : 16'sh0000; // RQ7

    // weighted terms; zero feedback gains leave only feedforward
    wire signed [47:0] p_term = 48'(prop_gain_q) * 48'(err_q); // RQ2 RQ14
    wire signed [47:0] i_term = 48'(int_gain_q) * 48'(integ_q); // RQ2 RQ14
    wire signed [47:0] d_term = 48'(deriv_gain_q) * 48'(dfilt_q); // RQ2 RQ14
    wire signed [47:0] s_term = 48'(speed_ff_gain_q) * 48'(ff_speed); // RQ5
    wire signed [47:0] a_term = 48'(accel_ff_gain_q) * 48'(ff_accel); // RQ6
    wire signed [47:0] sum_all = p_term + i_term + d_term + s_term + a_term; // RQ2
    wire signed [15:0] torque_next = sat16(sum_all >>> regulator_pkg::OUT_SHIFT); // RQ15

    // ---------------- sequencer ----------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            regulator_pkg::ST_IDLE:
            begin
                if (sample_tick)
                begin
                    state_d = regulator_pkg::ST_ERROR;
                end
            end
            regulator_pkg::ST_ERROR: state_d = regulator_pkg::ST_TERMS;
            regulator_pkg::ST_TERMS: state_d = regulator_pkg::ST_SUM;
            regulator_pkg::ST_SUM: state_d = regulator_pkg::ST_IDLE;
            default: state_d = regulator_pkg::ST_IDLE;
        endcase
    end

    wire in_error = (state_q == regulator_pkg::ST_ERROR);
    wire in_terms = (state_q == regulator_pkg::ST_TERMS);
    wire in_sum = (state_q == regulator_pkg::ST_SUM);

    always_comb
    begin
        evt_set = '0;
        evt_set[regulator_pkg::EVT_OVER_ERROR_BIT] = in_error & err_exceeds; // RQ12
        evt_set[regulator_pkg::EVT_SAMPLE_DONE_BIT] = in_sum;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= regulator_pkg::ST_IDLE;
            sample_cnt_q <= '0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            // counter free-runs while enabled so the period stays fixed
            sample_cnt_q <= (!enable_q || sample_tick) ? '0 : sample_cnt_q + 32'd1; // RQ15
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            follow_err_q <= '0;
            err_q <= '0;
        end
        else if (ce && in_error)
        begin
            follow_err_q <= err_report; // RQ10
            err_q <= err_banded; // RQ8
        end
    end

    // integrator and filter restart from zero when regulation is disabled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            integ_q <= '0;
            dfilt_q <= '0;
            err_prev_q <= '0;
        end
        else if (ce && !enable_q)
        begin
            integ_q <= '0;
            dfilt_q <= '0;
            err_prev_q <= '0;
        end
        else if (ce && in_terms)
        begin
            integ_q <= integ_clamped[15:0]; // RQ3
            dfilt_q <= dfilt_next; // RQ4
            err_prev_q <= err_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            torque_q <= '0;
        end
        else if (ce && in_sum)
        begin
            torque_q <= torque_next; // RQ13 RQ15
        end
    end

    // ---------------- register writes ----------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prop_gain_q <= regulator_pkg::GAIN_RESET;
            int_gain_q <= regulator_pkg::GAIN_RESET;
            deriv_gain_q <= regulator_pkg::GAIN_RESET;
            integral_limit_q <= regulator_pkg::LIMIT_RESET;
            deriv_delay_q <= regulator_pkg::DELAY_RESET;
            speed_ff_gain_q <= regulator_pkg::GAIN_RESET;
            accel_ff_gain_q <= regulator_pkg::GAIN_RESET;
            dead_band_q <= regulator_pkg::DEAD_BAND_RESET;
            err_max_q <= regulator_pkg::ERR_MAX_RESET;
            enable_q <= regulator_pkg::CTRL_RESET;
            irq_mask_q <= regulator_pkg::EVT_RESET;
        end
        else if (ce)
        begin
            if (wr_kp) prop_gain_q <= hwdata[15:0];
            if (wr_ki) int_gain_q <= hwdata[15:0];
            if (wr_kd) deriv_gain_q <= hwdata[15:0];
            if (wr_lim) integral_limit_q <= hwdata[15:0];
            if (wr_dly) deriv_delay_q <= hwdata[15:0];
            if (wr_sff) speed_ff_gain_q <= hwdata[15:0];
            if (wr_aff) accel_ff_gain_q <= hwdata[15:0];
            if (wr_db) dead_band_q <= hwdata[15:0];
            if (wr_emax) err_max_q <= hwdata[15:0];
            if (wr_ctrl) enable_q <= hwdata[regulator_pkg::CTRL_ENABLE_BIT];
            if (wr_mask) irq_mask_q <= hwdata[regulator_pkg::EVT_WIDTH-1:0];
        end
    end

    // sticky events: a new event in the clearing cycle wins over the clear
    wire [1:0] stat_clr = wr_stat ? hwdata[regulator_pkg::EVT_WIDTH-1:0] : 2'h0;
    wire [1:0] stat_next = (irq_status_q & ~stat_clr) | evt_set; // RQ12
    wire irq_next = |(stat_next & irq_mask_q);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status_q <= regulator_pkg::EVT_RESET;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq_status_q <= stat_next;
            irq <= irq_next;
        end
    end

    // ---------------- read path ----------------
    wire [15:0] rd_half =
        (a_idx == regulator_pkg::IDX_PROP_GAIN) ? prop_gain_q :
        (a_idx == regulator_pkg::IDX_INT_GAIN) ? int_gain_q :
        (a_idx == regulator_pkg::IDX_DERIV_GAIN) ? deriv_gain_q :
        (a_idx == regulator_pkg::IDX_INTEGRAL_LIMIT) ? integral_limit_q :
        (a_idx == regulator_pkg::IDX_DERIV_DELAY) ? deriv_delay_q :
        (a_idx == regulator_pkg::IDX_SPEED_FF_GAIN) ? speed_ff_gain_q :
        (a_idx == regulator_pkg::IDX_ACCEL_FF_GAIN) ? accel_ff_gain_q :
        (a_idx == regulator_pkg::IDX_DEAD_BAND) ? dead_band_q :
        (a_idx == regulator_pkg::IDX_FOLLOW_ERR) ? follow_err_q :
        (a_idx == regulator_pkg::IDX_FOLLOW_ERR_MAX) ? err_max_q :
        (a_idx == regulator_pkg::IDX_TORQUE_REQ) ? torque_q :
        (a_idx == regulator_pkg::IDX_CONTROL) ? {15'h0000, enable_q} :
        (a_idx == regulator_pkg::IDX_IRQ_STATUS) ? {14'h0000, irq_status_q} :
        (a_idx == regulator_pkg::IDX_IRQ_MASK) ? {14'h0000, irq_mask_q} : 16'h0000;
    // unmapped addresses read zero; the status read is taken before any same-edge clear
    wire [31:0] rd_word = in_range ? {16'h0000, rd_half} : 32'h0000_0000; // RQ10 RQ13

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
            hrdata_q <= '0;
            hreadyout_q <= 1'b1;
            hresp_q <= regulator_pkg::HRESP_OKAY;
        end
        else if (ce)
        begin
            wr_pend_q <= wr_start;
            wr_idx_q <= a_idx;
            hrdata_q <= rd_start ? rd_word : 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q <= regulator_pkg::HRESP_OKAY;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign torque_request = torque_q;
    assign over_error = irq_status_q[regulator_pkg::EVT_OVER_ERROR_BIT];

endmodule

// ==== core/regulator_pkg.sv ====
package regulator_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_PROP_GAIN = 10'h12c;
    localparam logic [9:0] IDX_INT_GAIN = 10'h12d;
    localparam logic [9:0] IDX_DERIV_GAIN = 10'h12e;
    localparam logic [9:0] IDX_INTEGRAL_LIMIT = 10'h12f;
    localparam logic [9:0] IDX_DERIV_DELAY = 10'h130;
    localparam logic [9:0] IDX_SPEED_FF_GAIN = 10'h131;
    localparam logic [9:0] IDX_ACCEL_FF_GAIN = 10'h132;
    localparam logic [9:0] IDX_DEAD_BAND = 10'h133;
    localparam logic [9:0] IDX_FOLLOW_ERR = 10'h134;
    localparam logic [9:0] IDX_FOLLOW_ERR_MAX = 10'h135;
    localparam logic [9:0] IDX_TORQUE_REQ = 10'h136;
    localparam logic [9:0] IDX_CONTROL = 10'h140;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h141;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h142;

    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 11;

    // field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int EVT_OVER_ERROR_BIT = 0;
    localparam int EVT_SAMPLE_DONE_BIT = 1;
    localparam int EVT_WIDTH = 2;

    // reset values
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [15:0] DEAD_BAND_RESET = 16'h0000;
    localparam logic [15:0] ERR_MAX_RESET = 16'h7fff;
    localparam logic [1:0] EVT_RESET = 2'h0;
    localparam logic CTRL_RESET = 1'b0;

    // datapath scaling
    localparam int ERR_SCALE_SHIFT = 4;
    localparam int OUT_SHIFT = 8;
    localparam logic [3:0] DELAY_MAX = 4'h8;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SAMPLE_PERIOD_NS = 50000;
    localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000) / CLK_PERIOD_PS;

    // AHB-Lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic signed [31:0] target;
        logic signed [31:0] position;
        logic signed [15:0] speed;
        logic signed [15:0] ramp_speed;
        logic signed [15:0] ramp_accel;
        logic ramp_active;
    } feedback_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ERROR = 4'b0010,
        ST_TERMS = 4'b0100,
        ST_SUM = 4'b1000
    } reg_state_t;

endpackage

// ==== testbench/pid_regulator_feedforward_assertions.sv ====
`timescale 1ns/1ps
module pid_regulator_feedforward_assertions #(
    parameter int SAMPLE_CYCLES = 8
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic ce, // clock enable
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire regulator_pkg::feedback_t fb, // feedback inputs
    input wire logic signed [15:0] torque_request, // torque
    input wire logic over_error, // sticky flag
    input wire logic irq // interrupt
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire take = hsel && hready && ce && htrans == regulator_pkg::HTRANS_NONSEQ
        && haddr[31:12] == 20'h0_0000;
    wire [9:0] idx = haddr[11:2];
    logic rd_q, rdt_q, wr_q, en_q;
    logic [9:0] wi_q;
    logic [1:0] mask_q;
    logic signed [15:0] last_q;
    logic [15:0] cnt_q;
    wire chg = torque_request != last_q;

    // shadows change at the edge that ends the data phase, as the registers do
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_q <= 1'b0;
            rdt_q <= 1'b0;
            wr_q <= 1'b0;
            wi_q <= 10'h000;
            en_q <= 1'b0;
            mask_q <= 2'h0;
            last_q <= 16'sh0000;
            cnt_q <= 16'hffff;
        end
        else
        begin
            rd_q <= take && !hwrite;
            rdt_q <= take && !hwrite && idx == regulator_pkg::IDX_TORQUE_REQ;
            wr_q <= take && hwrite;
            wi_q <= idx;
            if (wr_q && wi_q == regulator_pkg::IDX_CONTROL)
                en_q <= hwdata[0];
            if (wr_q && wi_q == regulator_pkg::IDX_IRQ_MASK)
                mask_q <= hwdata[1:0];
            last_q <= torque_request;
            cnt_q <= chg ? 16'h0001 : cnt_q + {15'h0000, cnt_q != 16'hffff};
        end
    end

    property p_bus_okay;
        take |-> hreadyout && hresp == regulator_pkg::HRESP_OKAY ##1 hreadyout;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer late or not okay");
    property p_read_idle;
        !rd_q |-> hrdata == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read");
    property p_read_upper;
        rd_q |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("read upper half not zero");
    property p_read_torque;
        rdt_q |-> hrdata[15:0] == $past(torque_request);
    endproperty
    a_read_torque: assert property (p_read_torque) else $error("torque read mismatch");
    property p_torque_rate;
        chg |-> cnt_q >= SAMPLE_CYCLES;
    endproperty
    a_torque_rate: assert property (p_torque_rate) else $error("torque updated too often");
    property p_torque_frozen;
        !en_q [*5] |-> $stable(torque_request);
    endproperty
    a_torque_frozen: assert property (p_torque_frozen) else $error("torque moved while off");
    property p_over_sticky;
        $fell(over_error) |-> $past(wr_q && wi_q == regulator_pkg::IDX_IRQ_STATUS && hwdata[0]);
    endproperty
    a_over_sticky: assert property (p_over_sticky) else $error("over-error fell uncleared");
    property p_irq_masked;
        $past(mask_q) == 2'h0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
    property p_irq_over;
        $past(over_error && mask_q[0]) && over_error |-> irq;
    endproperty
    a_irq_over: assert property (p_irq_over) else $error("irq missing for over-error");

    c_over_irq: cover property (over_error && irq);
    c_torque_change: cover property (chg);
    c_torque_read: cover property (rdt_q);
endmodule

bind pid_regulator_feedforward pid_regulator_feedforward_assertions #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
) pid_regulator_feedforward_assertions_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fb(fb), .torque_request(torque_request), .over_error(over_error), .irq(irq));

// ==== testbench/pid_regulator_feedforward_tb.sv ====
`timescale 1ns/1ps
module pid_regulator_feedforward_tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, over_error, irq;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic signed [15:0] torque_request;
    regulator_pkg::feedback_t fb;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    // a short sample period keeps the run small
    pid_regulator_feedforward #(.SAMPLE_CYCLES(8)) pid_regulator_feedforward_inst (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fb(fb),
        .torque_request(torque_request), .over_error(over_error), .irq(irq));

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        hwrite <= wr;
        htrans <= regulator_pkg::HTRANS_NONSEQ;
        haddr <= {20'h0_0000, idx, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rv = hrdata;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        xfer(1'b1, idx, {16'h0000, d});
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [15:0] exp);
        xfer(1'b0, idx, 32'h0000_0000);
        chk(rv, {16'h0000, exp});
    endtask

    // two sample-done events after the call, so the first may straddle a config write
    task automatic settle();
        repeat (2)
        begin
            wr(regulator_pkg::IDX_IRQ_STATUS, 16'h0002);
            while (rv[1] !== 1'b1) xfer(1'b0, regulator_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
        end
    endtask

    task automatic next_torque(input logic [15:0] exp);
        logic [15:0] was;
        was = torque_request;
        while (torque_request === was) @(posedge hclk);
        chk({16'h0000, torque_request}, {16'h0000, exp});
    endtask

    task automatic t_regs();
        for (int i = 'h12c; i <= 'h142; i++) rd_chk(i[9:0], i == 'h135 ? 16'h7fff : 16'h0000);
        for (int i = 'h12c; i < 'h140; i++) wr(i[9:0], 16'h8000 | i[15:0]);
        for (int i = 'h12c; i < 'h140; i++)
            rd_chk(i[9:0], (i < 'h134 || i == 'h135) ? 16'h8000 | i[15:0] : 16'h0000);
        for (int i = 'h12c; i < 'h140; i++) wr(i[9:0], i == 'h135 ? 16'h7fff : 16'h0000);
    endtask

    task automatic t_prop();
        int tg[4] = '{5, -3, 3000, -3000};
        logic [15:0] ef[4] = '{16'h0050, 16'hffd0, 16'h7fff, 16'h8000};
        fb.position <= 32'sd1000;
        fb.target <= 32'sd1005;
        wr(regulator_pkg::IDX_PROP_GAIN, 16'h0100);
        wr(regulator_pkg::IDX_CONTROL, 16'h0001);
        wr(regulator_pkg::IDX_DEAD_BAND, 16'h0051);
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'h0000);
        rd_chk(regulator_pkg::IDX_FOLLOW_ERR, 16'h0050);
        wr(regulator_pkg::IDX_DEAD_BAND, 16'h0050);
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'h0050);
        wr(regulator_pkg::IDX_DEAD_BAND, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            fb.target <= 1000 + tg[k];
            settle();
            rd_chk(regulator_pkg::IDX_FOLLOW_ERR, ef[k]);
            rd_chk(regulator_pkg::IDX_TORQUE_REQ, ef[k]);
        end
        wr(regulator_pkg::IDX_PROP_GAIN, 16'h0000);
        wr(regulator_pkg::IDX_CONTROL, 16'h0000);
    endtask

    task automatic t_integral();
        wr(regulator_pkg::IDX_INT_GAIN, 16'h0100);
        wr(regulator_pkg::IDX_INTEGRAL_LIMIT, 16'h0064);
        fb.target <= 32'sd1005;
        wr(regulator_pkg::IDX_CONTROL, 16'h0001);
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'h0064);
        fb.target <= 32'sd995;
        settle();
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'hff9c);
        wr(regulator_pkg::IDX_INT_GAIN, 16'h0000);
        wr(regulator_pkg::IDX_CONTROL, 16'h0000);
    endtask

    task automatic t_deriv();
        wr(regulator_pkg::IDX_DERIV_GAIN, 16'h0100);
        fb.target <= 32'sd1000;
        wr(regulator_pkg::IDX_CONTROL, 16'h0001);
        settle();
        fb.target <= 32'sd1005;
        next_torque(16'h0050);
        next_torque(16'h0000);
        wr(regulator_pkg::IDX_DERIV_DELAY, 16'h0001);
        settle();
        fb.target <= 32'sd1000;
        next_torque(16'hffd8);
        next_torque(16'hffec);
        wr(regulator_pkg::IDX_DERIV_GAIN, 16'h0000);
        wr(regulator_pkg::IDX_CONTROL, 16'h0000);
    endtask

    task automatic t_feedforward();
        fb.target <= 32'sd1005;
        fb.speed <= 16'sd100;
        fb.ramp_speed <= 16'sd7;
        fb.ramp_accel <= 16'sd9;
        wr(regulator_pkg::IDX_SPEED_FF_GAIN, 16'h0100);
        wr(regulator_pkg::IDX_ACCEL_FF_GAIN, 16'h0100);
        wr(regulator_pkg::IDX_CONTROL, 16'h0001);
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'h0064);
        fb.ramp_active <= 1'b1;
        settle();
        rd_chk(regulator_pkg::IDX_TORQUE_REQ, 16'h0010);
        wr(regulator_pkg::IDX_CONTROL, 16'h0000);
    endtask

    task automatic t_over();
        chk({31'h0, over_error}, 32'h0000_0001);
        wr(regulator_pkg::IDX_IRQ_STATUS, 16'h0003);
        wr(regulator_pkg::IDX_FOLLOW_ERR_MAX, 16'h0050);
        wr(regulator_pkg::IDX_CONTROL, 16'h0001);
        settle();
        chk({31'h0, over_error}, 32'h0000_0000);
        wr(regulator_pkg::IDX_FOLLOW_ERR_MAX, 16'h004f);
        settle();
        chk({30'h0, irq, over_error}, 32'h0000_0001);
        wr(regulator_pkg::IDX_IRQ_MASK, 16'h0001);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(regulator_pkg::IDX_CONTROL, 16'h0000);
        wr(regulator_pkg::IDX_IRQ_STATUS, 16'h0003);
        repeat (2) @(posedge hclk);
        chk({30'h0, irq, over_error}, 32'h0000_0000);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        fb = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_prop();
        t_integral();
        t_deriv();
        t_feedforward();
        t_over();
        final_report();
    end
endmodule
